// ==== rtl/amd_consts.svh ====
// Constants for the address-mode byte decoder
//
// Functional notes
// (RULE1) Addressing mode comes from the address-mode byte following the primary opcode.
// (RULE2) Implied-addressing instructions (push, pop) use no address-mode byte.
// (RULE3) In 32-bit addressing, SIB byte follows when r/m is 100 and mod not 11.
// (RULE4) With SIB byte, address form comes from mod, scale, index and base together.
// (RULE5) Middle three bits act as opcode extension or register field per instruction.
// (RULE6) Address-mode byte uses 16-bit map or 32-bit map by address size.
// (RULE7) 16-bit addressing uses 16-bit components; 32-bit addressing uses 32-bit components.
// (RULE8) 16-bit mod 00 selects BX+SI..BX forms, r/m 110 direct; BP forms use stack.
// (RULE9) 16-bit mod 01 adds byte displacement; r/m 110 is BP in stack segment.
// (RULE10) 16-bit mod 10 is as mod 01 but with halfword displacement.
// (RULE11) Mod 11 names a register operand by r/m; no memory address is made.
// (RULE12) 16-bit data: w=0 picks byte registers, w=1 picks 16-bit registers.
// (RULE13) 32-bit data: w=0 picks byte registers, w=1 picks 32-bit registers.
// (RULE14) The register field uses the same width-dependent mapping as register-form r/m.
// (RULE15) 32-bit mod 00 r/m 101 is direct word displacement; others register indirect.
// (RULE16) 32-bit mod 01 adds byte displacement; r/m 101 is EBP in stack segment.
// (RULE17) 32-bit mod 10 adds word displacement; EBP defaults to stack segment.
// (RULE18) Scale multiplies index by 1,2,4,8; index 100 means none, scale must be 00.
// (RULE19) SIB with mod 00 and base 101 is word displacement plus scaled index.
// (RULE20) Byte displacement is sign-extended; address sum wraps at address width.
`ifndef AMD_CONSTS_SVH
`define AMD_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_MODRM 8'h04
`define OFS_SIB 8'h08
`define OFS_DISP 8'h0c
`define OFS_BASEVAL 8'h10
`define OFS_INDEXVAL 8'h14
`define OFS_DECODE 8'h18
`define OFS_REGSEL 8'h1c
`define OFS_EADDR 8'h20

// ----------------------------------------------------------------
// Control field positions and reset values
// ----------------------------------------------------------------
`define CTRL_ADDR32 0
`define CTRL_DATA32 1
`define CTRL_WBIT 2
`define CTRL_IMPLIED 3
`define CTRL_REGFIELD 4
`define CTRL_RESET 5'h00
`define BYTE_RESET 8'h00
`define WORD_RESET 32'h0000_0000

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define MOD_REG 2'b11
`define MOD_NODISP 2'b00
`define MOD_BYTEDISP 2'b01
`define MOD_WORDDISP 2'b10
`define RM_SIB 3'b100
`define RM_DIRECT16 3'b110
`define RM_EBP 3'b101
`define IDX_NONE 3'b100
`define SCALE_ONE 2'b00
`define REG_BX 3'h3
`define REG_SP 3'h4
`define REG_BP 3'h5
`define REG_SI 3'h6
`define REG_DI 3'h7

`endif

// ==== rtl/amd_pkg.sv ====
// Types shared by the address-mode byte decoder
package amd_pkg;
  typedef enum logic [1:0] {DISP_NONE, DISP_BYTE, DISP_HALF, DISP_WORD} disp_size_type;
  typedef logic [2:0] reg_code_type;
  typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD} opnd_size_type;
endpackage

// ==== rtl/addr16_map.sv ====
// 16-bit address-mode map
`timescale 1ns/1ps
`include "amd_consts.svh"
module addr16_map (
  input wire logic [1:0] modField,
  input wire logic [2:0] rmField,
  output logic hasBase,
  output amd_pkg::reg_code_type baseCode,
  output logic hasIndex,
  output amd_pkg::reg_code_type indexCode,
  output amd_pkg::disp_size_type dispSize,
  output logic stackSeg
);
  import amd_pkg::*;

  // Base and index per r/m code
  always_comb begin
    hasBase = 1'b1;
    baseCode = `REG_BX;
    hasIndex = 1'b1;
    indexCode = rmField[0] ? `REG_DI : `REG_SI;
    case (rmField)
      3'b000, 3'b001: baseCode = `REG_BX; // [RULE8]
      3'b010, 3'b011: baseCode = `REG_BP;
      3'b100, 3'b101: hasBase = 1'b0;
      3'b110: begin
        hasIndex = 1'b0;
        baseCode = `REG_BP; // [RULE9]
        hasBase = (modField != `MOD_NODISP); // [RULE8]
      end
      default: hasIndex = 1'b0;
    endcase
  end

  // Displacement size and stack default
  always_comb begin
    case (modField)
      `MOD_NODISP: dispSize = (rmField == `RM_DIRECT16) ? DISP_HALF : DISP_NONE; // [RULE8]
      `MOD_BYTEDISP: dispSize = DISP_BYTE; // [RULE9]
      `MOD_WORDDISP: dispSize = DISP_HALF; // [RULE10]
      default: dispSize = DISP_NONE;
    endcase
  end
  assign stackSeg = hasBase && (baseCode == `REG_BP); // [RULE8]

endmodule // addr16_map

// ==== rtl/addr32_map.sv ====
// 32-bit address-mode map, with scale-index-base byte
`timescale 1ns/1ps
`include "amd_consts.svh"
module addr32_map (
  input wire logic [1:0] modField,
  input wire logic [2:0] rmField,
  input wire logic [7:0] sibByte,
  output logic sibNeeded,
  output logic hasBase,
  output amd_pkg::reg_code_type baseCode,
  output logic hasIndex,
  output amd_pkg::reg_code_type indexCode,
  output logic [1:0] scale,
  output amd_pkg::disp_size_type dispSize,
  output logic stackSeg,
  output logic undefinedForm
);
  import amd_pkg::*;

  // Second byte presence and field pick
  assign sibNeeded = (rmField == `RM_SIB) && (modField != `MOD_REG); // [RULE3]
  assign baseCode = sibNeeded ? sibByte[2:0] : rmField; // [RULE4]
  assign indexCode = sibByte[5:3];
  assign hasIndex = sibNeeded && (indexCode != `IDX_NONE); // [RULE18]
  assign scale = hasIndex ? sibByte[7:6] : `SCALE_ONE; // [RULE18]
  assign undefinedForm = sibNeeded && !hasIndex && (sibByte[7:6] != `SCALE_ONE);
  wire direct = (modField == `MOD_NODISP) && (baseCode == `RM_EBP); // [RULE15] [RULE19]
  assign hasBase = !direct;
  assign stackSeg = hasBase && (baseCode == `REG_SP || baseCode == `REG_BP); // [RULE16] [RULE17]

  // Displacement size
  always_comb begin
    case (modField)
      `MOD_NODISP: dispSize = direct ? DISP_WORD : DISP_NONE; // [RULE15]
      `MOD_BYTEDISP: dispSize = DISP_BYTE; // [RULE16]
      `MOD_WORDDISP: dispSize = DISP_WORD; // [RULE17]
      default: dispSize = DISP_NONE;
    endcase
  end

endmodule // addr32_map

// ==== rtl/addr_mode_decoder.sv ====
// Address-mode byte decoder with AHB-Lite register access
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "amd_consts.svh"
module addr_mode_decoder (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  import amd_pkg::*;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic [4:0] ctrl_reg;
  logic [7:0] modrm_reg;
  logic [7:0] sib_reg;
  logic [31:0] disp_reg;
  logic [31:0] baseVal_reg;
  logic [31:0] indexVal_reg;
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic [31:0] rdata_reg;
  logic [31:0] readData;

  // Address phase acceptance; only word transfers are expected
  wire accept = hsel && htrans[1] && hready;
  wire addrHit = (haddr[31:8] == 24'h0);
  wire [7:0] rdOfs = addrHit ? haddr[7:0] : 8'hff;

  // Data phase write strobes
  wire wrCtrl = wrPend_reg && (wrAddr_reg == `OFS_CTRL);
  wire wrModrm = wrPend_reg && (wrAddr_reg == `OFS_MODRM);
  wire wrSib = wrPend_reg && (wrAddr_reg == `OFS_SIB);
  wire wrDisp = wrPend_reg && (wrAddr_reg == `OFS_DISP);
  wire wrBase = wrPend_reg && (wrAddr_reg == `OFS_BASEVAL);
  wire wrIndex = wrPend_reg && (wrAddr_reg == `OFS_INDEXVAL);

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // Bus phase tracking and read capture
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      rdata_reg <= `WORD_RESET;
    end else begin
      wrPend_reg <= accept && hwrite;
      wrAddr_reg <= addrHit ? haddr[7:0] : 8'hff;
      if (accept && !hwrite) begin
        rdata_reg <= readData;
      end
    end
  end

  // Software-written registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `CTRL_RESET;
      modrm_reg <= `BYTE_RESET;
      sib_reg <= `BYTE_RESET;
    end else begin
      if (wrCtrl) ctrl_reg <= hwdata[4:0];
      if (wrModrm) modrm_reg <= hwdata[7:0]; // [RULE1]
      if (wrSib) sib_reg <= hwdata[7:0];
    end
  end

  // Address component registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      disp_reg <= `WORD_RESET;
      baseVal_reg <= `WORD_RESET;
      indexVal_reg <= `WORD_RESET;
    end else begin
      if (wrDisp) disp_reg <= hwdata;
      if (wrBase) baseVal_reg <= hwdata;
      if (wrIndex) indexVal_reg <= hwdata;
    end
  end

  // ----------------------------------------------------------------
  // Field split and mode selection
  // ----------------------------------------------------------------
  wire addr32 = ctrl_reg[`CTRL_ADDR32];
  wire data32 = ctrl_reg[`CTRL_DATA32];
  wire wBit = ctrl_reg[`CTRL_WBIT];
  wire implied = ctrl_reg[`CTRL_IMPLIED];
  wire regFieldUsed = ctrl_reg[`CTRL_REGFIELD];
  wire [1:0] modF = modrm_reg[7:6]; // [RULE1]
  wire [2:0] midF = modrm_reg[5:3];
  wire [2:0] rmF = modrm_reg[2:0];

  // Implied addressing skips the byte; mod 11 is register form
  wire isRegForm = !implied && (modF == `MOD_REG); // [RULE2] [RULE11]
  wire memForm = !implied && (modF != `MOD_REG); // [RULE11]

  // Middle bits go to register select or opcode extension
  wire extValid = !implied && !regFieldUsed; // [RULE5]
  wire regValid = !implied && regFieldUsed; // [RULE5]

  // ----------------------------------------------------------------
  // Address maps
  // ----------------------------------------------------------------
  logic b16;
  logic i16;
  logic s16;
  reg_code_type bc16;
  reg_code_type ic16;
  disp_size_type ds16;
  logic sib32;
  logic b32;
  logic i32;
  logic s32;
  logic undef32;
  logic [1:0] sc32;
  reg_code_type bc32;
  reg_code_type ic32;
  disp_size_type ds32;

  addr16_map map16 (
    .modField(modF),
    .rmField(rmF),
    .hasBase(b16),
    .baseCode(bc16),
    .hasIndex(i16),
    .indexCode(ic16),
    .dispSize(ds16),
    .stackSeg(s16)
  );

  addr32_map map32 (
    .modField(modF),
    .rmField(rmF),
    .sibByte(sib_reg),
    .sibNeeded(sib32),
    .hasBase(b32),
    .baseCode(bc32),
    .hasIndex(i32),
    .indexCode(ic32),
    .scale(sc32),
    .dispSize(ds32),
    .stackSeg(s32),
    .undefinedForm(undef32)
  );

  // Pick the map by address size, gated by form
  wire sibNeeded = memForm && addr32 && sib32; // [RULE3]
  wire hasBase = memForm && (addr32 ? b32 : b16); // [RULE6]
  wire hasIndex = memForm && (addr32 ? i32 : i16); // [RULE6]
  wire [2:0] baseCode = addr32 ? bc32 : bc16;
  wire [2:0] indexCode = addr32 ? ic32 : ic16;
  wire [1:0] scale = (memForm && addr32) ? sc32 : `SCALE_ONE; // [RULE18]
  wire undefForm = memForm && addr32 && undef32;
  wire stackSeg = implied || (memForm && (addr32 ? s32 : s16)); // [RULE2]
  disp_size_type dispSize;
  assign dispSize = memForm ? (addr32 ? ds32 : ds16) : DISP_NONE; // [RULE4]

  // ----------------------------------------------------------------
  // Register operand selection
  // ----------------------------------------------------------------
  logic [2:0] physReg [2];
  logic highByte [2];
  opnd_size_type opSize;
  wire [2:0] fieldSrc [2];

  assign fieldSrc[0] = rmF;
  assign fieldSrc[1] = midF;
  assign opSize = !wBit ? SIZE_BYTE : (data32 ? SIZE_WORD : SIZE_HALF); // [RULE12] [RULE13]

  // Byte codes 4..7 name the high byte of registers 0..3
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gSel
      assign physReg[g] = wBit ? fieldSrc[g] : {1'b0, fieldSrc[g][1:0]}; // [RULE14]
      assign highByte[g] = !wBit && fieldSrc[g][2]; // [RULE12] [RULE13]
    end
  endgenerate

  // ----------------------------------------------------------------
  // Effective address
  // ----------------------------------------------------------------
  wire [31:0] baseRaw = hasBase ? baseVal_reg : 32'h0;
  wire [31:0] idxRaw = hasIndex ? indexVal_reg : 32'h0;
  wire [31:0] baseOp = addr32 ? baseRaw : {16'h0, baseRaw[15:0]}; // [RULE7]
  wire [31:0] idxOp = addr32 ? idxRaw : {16'h0, idxRaw[15:0]}; // [RULE7]
  wire [31:0] idxScaled = idxOp << scale; // [RULE18]
  logic [31:0] dispOp;

  // Displacement extended to address width
  always_comb begin
    case (dispSize)
      DISP_BYTE: dispOp = {{24{disp_reg[7]}}, disp_reg[7:0]}; // [RULE20]
      DISP_HALF: dispOp = {16'h0, disp_reg[15:0]};
      DISP_WORD: dispOp = disp_reg;
      default: dispOp = 32'h0;
    endcase
  end

  // Sum wraps at the address width
  wire [31:0] eaSum = baseOp + idxScaled + dispOp; // [RULE20]
  wire [31:0] eaddr = !memForm ? 32'h0 : (addr32 ? eaSum : {16'h0, eaSum[15:0]}); // [RULE7]

  // ----------------------------------------------------------------
  // Status words and read mux
  // ----------------------------------------------------------------
  wire [31:0] decodeWord = {6'h0, implied, undefForm, 1'b0, midF, extValid, regValid,
    scale, 1'b0, indexCode, 1'b0, baseCode, 1'b0, hasIndex, hasBase, stackSeg,
    dispSize, isRegForm, sibNeeded};
  wire [31:0] regSelWord = {14'h0, opSize, 3'h0, highByte[1], 1'b0, physReg[1],
    1'b0, highByte[0], 1'b0, physReg[0], isRegForm, regValid};

  assign readData =
    (rdOfs == `OFS_CTRL) ? {27'h0, ctrl_reg} :
    (rdOfs == `OFS_MODRM) ? {24'h0, modrm_reg} :
    (rdOfs == `OFS_SIB) ? {24'h0, sib_reg} :
    (rdOfs == `OFS_DISP) ? disp_reg :
    (rdOfs == `OFS_BASEVAL) ? baseVal_reg :
    (rdOfs == `OFS_INDEXVAL) ? indexVal_reg :
    (rdOfs == `OFS_DECODE) ? decodeWord :
    (rdOfs == `OFS_REGSEL) ? regSelWord :
    (rdOfs == `OFS_EADDR) ? eaddr : 32'h0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_sib_after_write: assert property ( // [RULE3]
    wrModrm && addr32 && !implied && hwdata[2:0] == `RM_SIB && hwdata[7:6] != `MOD_REG
    |=> sibNeeded && $stable(ctrl_reg) [*1])
    else $error("SIB byte not expected after 32-bit r/m 100 write");

  a_sib_only_32: assert property ( // [RULE6]
    !addr32 |-> !sibNeeded && scale == `SCALE_ONE)
    else $error("SIB byte expected under 16-bit addressing");

  a_implied_fixed: assert property ( // [RULE2]
    implied |-> dispSize == DISP_NONE && !sibNeeded && stackSeg && eaddr == 32'h0)
    else $error("Implied addressing used the address-mode byte");

  a_reg_form_nomem: assert property ( // [RULE11]
    isRegForm |-> !hasBase && !hasIndex && dispSize == DISP_NONE && eaddr == 32'h0)
    else $error("Register form produced a memory address");

  a_bp16_stack: assert property ( // [RULE8]
    memForm && !addr32 && modF == `MOD_NODISP
    |-> stackSeg == (rmF == 3'b010 || rmF == 3'b011))
    else $error("16-bit mod 00 segment default wrong");

  a_direct16_disp: assert property ( // [RULE8]
    memForm && !addr32 && modF == `MOD_NODISP && rmF == `RM_DIRECT16
    |-> dispSize == DISP_HALF && !hasBase && !hasIndex)
    else $error("16-bit direct form wrong");

  a_d16_byte_bp: assert property ( // [RULE9]
    memForm && !addr32 && modF == `MOD_BYTEDISP && rmF == `RM_DIRECT16
    |-> dispSize == DISP_BYTE && baseCode == `REG_BP && stackSeg)
    else $error("16-bit mod 01 r/m 110 not BP byte form");

  a_d16_half_disp: assert property ( // [RULE10]
    memForm && !addr32 && modF == `MOD_WORDDISP |-> dispSize == DISP_HALF)
    else $error("16-bit mod 10 displacement not halfword");

  a_direct32_form: assert property ( // [RULE15]
    memForm && addr32 && modF == `MOD_NODISP && rmF == `RM_EBP
    |-> dispSize == DISP_WORD && !hasBase && !stackSeg)
    else $error("32-bit direct form wrong");

  a_ebp32_byte: assert property ( // [RULE16]
    memForm && addr32 && modF == `MOD_BYTEDISP && rmF == `RM_EBP
    |-> dispSize == DISP_BYTE && baseCode == `REG_BP && stackSeg)
    else $error("32-bit mod 01 EBP form wrong");

  a_ebp32_word: assert property ( // [RULE17]
    memForm && addr32 && modF == `MOD_WORDDISP && !sibNeeded && rmF == `RM_EBP
    |-> dispSize == DISP_WORD && stackSeg)
    else $error("32-bit mod 10 EBP form wrong");

  a_no_index: assert property ( // [RULE18]
    sibNeeded && sib_reg[5:3] == `IDX_NONE |-> !hasIndex && undefForm == (sib_reg[7:6] != 2'b00))
    else $error("Index 100 treated as an index");

  a_sib_base_direct: assert property ( // [RULE19]
    sibNeeded && modF == `MOD_NODISP && sib_reg[2:0] == `RM_EBP
    |-> !hasBase && dispSize == DISP_WORD)
    else $error("SIB base 101 in mod 00 not direct");

  a_wrap16: assert property ( // [RULE20]
    !addr32 |-> eaddr[31:16] == 16'h0)
    else $error("16-bit address exceeds 16 bits");

  a_byte_disp_sext: assert property ( // [RULE20]
    dispSize == DISP_BYTE |-> dispOp[31:8] == {24{disp_reg[7]}})
    else $error("Byte displacement not sign-extended");

  a_byte_regs: assert property ( // [RULE12]
    !wBit |-> opSize == SIZE_BYTE && physReg[0][2] == 1'b0 && highByte[0] == rmF[2])
    else $error("Byte register mapping wrong");

  a_reg_field_map: assert property ( // [RULE14]
    wBit |-> physReg[1] == midF && !highByte[1])
    else $error("Register field mapping wrong");

  a_word_regs: assert property ( // [RULE13]
    wBit && data32 |-> opSize == SIZE_WORD && physReg[0] == rmF && !highByte[0])
    else $error("Word register mapping wrong");

  a_half_regs: assert property ( // [RULE12]
    wBit && !data32 |-> opSize == SIZE_HALF && physReg[0] == rmF && !highByte[0])
    else $error("Halfword register mapping wrong");

  a_sib_fields: assert property ( // [RULE4]
    sibNeeded && hasIndex
    |-> indexCode == sib_reg[5:3] && scale == sib_reg[7:6] && baseCode == sib_reg[2:0])
    else $error("Scale-index-base fields not used for the address");

  a_read_data: assert property (
    accept && !hwrite && rdOfs == `OFS_CTRL |=> hrdata == {27'h0, $past(ctrl_reg)})
    else $error("Control read returned wrong data");

  c_sib_form: cover property (sibNeeded && hasIndex && scale == 2'b11);
  c_reg_form: cover property (isRegForm && wBit && data32);
  c_bp16: cover property (memForm && !addr32 && stackSeg);
  c_implied: cover property (implied && accept);
  c_undef_index: cover property (undefForm);

endmodule // addr_mode_decoder

// ==== bench/ahb_master_model.sv ====
// Bus-side partner that issues single AHB-Lite word transfers
`timescale 1ns/1ps
module ahb_master_model (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // One transfer: address phase, then data phase, each held until hready
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~addr; // Stale address is not left looking valid
    hwdata <= wr ? wdata : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    rdata = hrdata;
  endtask
endmodule // ahb_master_model

// ==== bench/addr_mode_decoder_tb.sv ====
// Self-checking bench for the address-mode byte decoder
`timescale 1ns/1ps
`include "amd_consts.svh"
module addr_mode_decoder_tb;
  import amd_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, hb, hi, st, w, dw;
  logic [31:0] haddr, hwdata, hrdata, rdat, dsp, ea, e;
  logic [1:0] htrans, md, ds, sc;
  logic [2:0] hsize, rm, g;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  addr_mode_decoder i_dut (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  ahb_master_model i_bus (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // 50 ns clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] expv, input logic [31:0] got);
    total_checks++;
    if (got !== expv) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    i_bus.xfer(1'b1, {24'h0, ofs}, d, rdat);
  endtask

  task automatic chk(input logic [7:0] ofs, input logic [31:0] m, input logic [31:0] expv,
                     input string what);
    i_bus.xfer(1'b0, {24'h0, ofs}, 32'h0, rdat);
    cmp(what, expv & m, rdat & m);
    cmp("hresp", 32'h0, {31'h0, hresp});
    cmp("hreadyout", 32'h1, {31'h0, hreadyout});
  endtask

  task automatic setup(input logic [4:0] c, input logic [7:0] mrm, sib,
                       input logic [31:0] dp, bv, iv);
    wr(`OFS_CTRL, {27'h0, c});
    wr(`OFS_MODRM, {24'h0, mrm});
    wr(`OFS_SIB, {24'h0, sib});
    wr(`OFS_DISP, dp);
    wr(`OFS_BASEVAL, bv);
    wr(`OFS_INDEXVAL, iv);
  endtask

  // Decode status and address, code fields compared only where present
  task automatic cdec(input logic sn, hb, hi, st, un, input logic [1:0] ds, sc,
                      input logic [2:0] bc, ic, input logic [31:0] ea);
    logic [31:0] x;
    logic [31:0] m;
    x = {7'h0, un, 6'h0, sc, 1'b0, ic, 1'b0, bc, 1'b0, hi, hb, st, ds, 1'b0, sn};
    m = 32'h0100_007f;
    if (hb) m |= 32'h0000_0700;
    if (hi) m |= 32'h0000_7000;
    if (sn && hi) m |= 32'h0003_0000;
    chk(`OFS_DECODE, m, x, "decode");
    chk(`OFS_EADDR, 32'hffff_ffff, ea, "eaddr");
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    for (int o = 0; o < 24; o += 4) chk(8'(o), 32'hffff_ffff, 32'h0, "reset value");
    wr(`OFS_CTRL, 32'hffff_ffff);
    chk(`OFS_CTRL, 32'hffff_ffff, 32'h0000_001f, "ctrl width");
    wr(8'h40, 32'hdead_beef);
    chk(8'h40, 32'hffff_ffff, 32'h0, "unmapped");
    $display("test registers done");
    // 16-bit map over every memory form
    for (int i = 0; i < 24; i++) begin
      md = i[4:3];
      rm = i[2:0];
      hb = rm < 4 || rm == 7 || (rm == 6 && md != 0);
      hi = rm < 6;
      st = hb && rm != 7 && rm > 1;
      ds = md == 0 ? (rm == 6 ? 2'd2 : 2'd0) : (md == 1 ? 2'd1 : 2'd2);
      dsp = ds == 1 ? 32'hffff_fff0 : (ds == 2 ? 32'h0000_80f0 : 32'h0);
      ea = ((hb ? 32'h5678 : 32'h0) + (hi ? 32'h1111 : 32'h0) + dsp) & 32'h0000_ffff;
      setup(5'h00, {md, 3'h2, rm}, 8'h00, 32'h0000_80f0, 32'h1234_5678, 32'h0000_1111);
      cdec(0, hb, hi, st, 0, ds, 0, (rm == 7 || rm < 2) ? 3'h3 : 3'h5,
           rm[0] ? 3'h7 : 3'h6, ea);
    end
    $display("test map16 done");
    // 32-bit map without and with the scale-index-base byte
    for (int i = 0; i < 48; i++) begin
      md = i[4:3];
      rm = i[2:0];
      hb = !(md == 0 && rm == 5);
      ds = md == 0 ? (rm == 5 ? 2'd3 : 2'd0) : (md == 1 ? 2'd1 : 2'd3);
      dsp = ds == 1 ? 32'hffff_ff80 : (ds == 3 ? 32'h8000_0080 : 32'h0);
      sc = rm[1:0];
      if (i < 24 && rm != 4) begin
        st = rm == 5 && md != 0;
        ea = (hb ? 32'hfedc_ba98 : 32'h0) + dsp;
        setup(5'h01, {md, 3'h0, rm}, 8'h00, 32'h8000_0080, 32'hfedc_ba98, 32'h0);
        cdec(0, hb, 0, st, 0, ds, 0, rm, 0, ea);
      end else if (i >= 24) begin
        md = 2'(i / 8 - 3);
        hb = !(md == 0 && rm == 5);
        ds = md == 0 ? (rm == 5 ? 2'd3 : 2'd0) : (md == 1 ? 2'd1 : 2'd3);
        dsp = ds == 1 ? 32'hffff_ff80 : (ds == 3 ? 32'h8000_0080 : 32'h0);
        st = rm == 4 || (rm == 5 && md != 0);
        ea = (hb ? 32'hfedc_ba98 : 32'h0) + (32'h0000_0111 << sc) + dsp;
        setup(5'h01, {md, 3'h0, 3'h4}, {sc, 3'h1, rm}, 32'h8000_0080, 32'hfedc_ba98,
              32'h0000_0111);
        cdec(1, hb, 1, st, 0, ds, sc, rm, 3'h1, ea);
      end
    end
    // No index: scale 00 is defined, scale 11 is flagged
    for (int i = 0; i < 2; i++) begin
      setup(5'h01, 8'h44, {i[0] ? 2'b11 : 2'b00, 3'h4, 3'h3}, 32'h0000_0010,
            32'h0000_1000, 32'h0000_0111);
      cdec(1, 1, 0, 0, i[0], 2'd1, 0, 3'h3, 0, 32'h0000_1010);
    end
    $display("test map32 done");
    // Register form across address size, data size and width bit
    for (int i = 0; i < 32; i++) begin
      dw = i[3];
      w = i[4];
      rm = i[2:0];
      g = 3'(7 - i[2:0]);
      e = {14'h0, w ? (dw ? 2'd2 : 2'd1) : 2'd0, 3'h0, !w && g[2], 1'b0,
           w ? g : {1'b0, g[1:0]}, 1'b0, !w && rm[2], 1'b0, w ? rm : {1'b0, rm[1:0]}, 2'b11};
      setup({2'b10, w, dw, i[0]}, {2'b11, g, rm}, 8'h25, 32'h0000_0040, 32'h0000_2000, 32'h1);
      chk(`OFS_REGSEL, 32'h0003_175f, e, "regsel");
      chk(`OFS_DECODE, 32'h0000_0003, 32'h2, "register form");
      chk(`OFS_EADDR, 32'hffff_ffff, 32'h0, "eaddr register form");
    end
    $display("test register done");
    // Middle bits as opcode extension, then as register field
    for (int i = 0; i < 2; i++) begin
      setup({i[0], 4'h1}, 8'h28, 8'h00, 32'h0, 32'h0, 32'h0);
      chk(`OFS_DECODE, 32'h00fc_0000, i[0] ? 32'h0054_0000 : 32'h0058_0000, "middle");
      chk(`OFS_REGSEL, 32'h0000_0001, {31'h0, i[0]}, "reg field valid");
    end
    // Implied addressing ignores an address-mode byte that asks for more
    setup(5'h09, 8'h84, 8'h00, 32'h0000_0100, 32'h0000_3000, 32'h0);
    chk(`OFS_DECODE, 32'h0200_001d, 32'h0200_0010, "implied");
    wr(`OFS_EADDR, 32'h0000_1234);
    chk(`OFS_EADDR, 32'hffff_ffff, 32'h0, "eaddr implied");
    $display("test opcode field done");
    close_out();
  end
endmodule // addr_mode_decoder_tb
